// [include/dps_map.svh]
// Offsets, field positions and codes for the discard pointer bit select block
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
`define DPS_ADDR_W          10
`define DPS_REG_OFFSET      10'h210
`define DPS_DATA_W          16
`define DPS_SEL_W           6
`define DPS_SEL2_LSB        0
`define DPS_SEL3_LSB        6
`define DPS_WR_MASK         16'h0fff
`define DPS_CODE_FORCE0     6'h30
`define DPS_CODE_TANDEM     6'h20
`define DPS_CODE_BUS        6'h30
`define DPS_CELL_W          32
`define DPS_RTE_W           16
`define DPS_SEL_RESET       6'h30
`define DPS_POS2            2
`define DPS_POS3            3
`define DPS_OFFSET_W        13
`endif

// [include/dps_pkg.sv]
// Types for the discard pointer bit select block
package dps_pkg;
  typedef struct packed {
    logic [31:0] cell_hdr;
    logic [15:0] tandem_hdr;
    logic [15:0] bus_hdr;
  } dps_hdr_t;

  typedef struct packed {
    logic [5:0] bit3_src;
    logic [5:0] bit2_src;
  } dps_sel_t;
endpackage

// [core/dps_bit_select.sv]
// Offset bits 2 and 3 of the discard state memory pointer, with select register
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`include "dps_map.svh"
module dps_bit_select
  import dps_pkg::*;
(
  input  wire logic                    i_clk,        // 125 MHz receive clock
  input  wire logic                    i_reset_n,    // Async reset, active low
  input  wire logic [`DPS_ADDR_W-1:0]  i_addr,       // Register address
  input  wire logic [`DPS_DATA_W-1:0]  i_wdata,      // Write data
  input  wire logic                    i_wr,         // Write strobe
  input  wire logic                    i_rd,         // Read strobe
  input  wire logic                    i_hdr_valid,  // Headers valid this cycle
  input  wire dps_hdr_t                i_hdr,        // Received headers
  input  wire logic [1:0]              i_offset_lo,  // Offset bits 1:0 from other selects
  input  wire logic [`DPS_OFFSET_W-5:0] i_offset_hi, // Offset bits 12:4 from other selects
  output logic [`DPS_DATA_W-1:0]       o_rdata,      // Read data, one cycle later
  output logic [`DPS_OFFSET_W-1:0]     o_offset,     // State memory offset
  output logic                         o_offset_vld  // Offset valid
);

  // ==========================================================================
  // Header bit selection
  // ==========================================================================
  function automatic logic pick_bit(input logic [5:0] code, input dps_hdr_t hdr);
    logic b;
    b = 1'b0;
    if (code == `DPS_CODE_FORCE0)
      b = 1'b0;
    else if (code >= `DPS_CODE_BUS)
      b = hdr.bus_hdr[code[3:0]];
    else if (code >= `DPS_CODE_TANDEM)
      b = hdr.tandem_hdr[code[3:0]];
    else
      b = hdr.cell_hdr[code[4:0]];
    return b;
  endfunction

  // ==========================================================================
  // Source range decode
  // ==========================================================================
  // Used by the second group of checks; the first group spells its ranges inline
  function automatic logic src_is_force(input logic [5:0] code);
    return (code == `DPS_CODE_FORCE0);
  endfunction

  function automatic logic src_is_cell(input logic [5:0] code);
    return (code < `DPS_CODE_TANDEM);
  endfunction

  function automatic logic src_is_tandem(input logic [5:0] code);
    return (code >= `DPS_CODE_TANDEM) && (code < `DPS_CODE_BUS);
  endfunction

  // Lowest bus code is taken by the force meaning
  function automatic logic src_is_bus(input logic [5:0] code);
    return (code > `DPS_CODE_BUS);
  endfunction

  // ==========================================================================
  // Select register
  // ==========================================================================
  dps_sel_t                    sel_r;
  dps_sel_t                    sel_nxt;
  logic [`DPS_DATA_W-1:0]      rdata_r;
  logic [`DPS_DATA_W-1:0]      rdata_nxt;
  logic                        hit;

  assign hit = (i_addr == `DPS_REG_OFFSET);

  always_comb
  begin
    sel_nxt   = sel_r;
    rdata_nxt = '0;
    if (i_wr && hit)
    begin
      sel_nxt.bit2_src = i_wdata[`DPS_SEL2_LSB +: `DPS_SEL_W];
      sel_nxt.bit3_src = i_wdata[`DPS_SEL3_LSB +: `DPS_SEL_W];
    end
    if (i_rd && hit)
      rdata_nxt = {4'h0, sel_r} & `DPS_WR_MASK;
  end

  // Reset to the forcing code so no header bit leaks before setup
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sel_r   <= {`DPS_SEL_RESET, `DPS_SEL_RESET};
      rdata_r <= '0;
    end
    else
    begin
      sel_r   <= sel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  // ==========================================================================
  // Offset build
  // ==========================================================================
  logic [`DPS_OFFSET_W-1:0]    offset_r;
  logic [`DPS_OFFSET_W-1:0]    offset_nxt;
  logic                        vld_r;
  logic                        vld_nxt;

  always_comb
  begin
    offset_nxt = offset_r;
    vld_nxt    = i_hdr_valid;
    if (i_hdr_valid)
    begin
      offset_nxt = {i_offset_hi,
                    pick_bit(sel_r.bit3_src, i_hdr),
                    pick_bit(sel_r.bit2_src, i_hdr),
                    i_offset_lo};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      offset_r <= '0;
      vld_r    <= 1'b0;
    end
    else
    begin
      offset_r <= offset_nxt;
      vld_r    <= vld_nxt;
    end
  end

  assign o_offset     = offset_r;
  assign o_offset_vld = vld_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence reg_write_s;
    i_wr && hit;
  endsequence

  sequence reg_read_s;
    i_rd && hit;
  endsequence

  sequence reg_idle_s;
    !(i_rd && hit);
  endsequence

  sequence reg_keep_s;
    !(i_wr && hit);
  endsequence

  sequence hdr_take_s;
    i_hdr_valid;
  endsequence

  sequence hdr_idle_s;
    !i_hdr_valid;
  endsequence

  field2_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    reg_write_s |=> sel_r.bit2_src == $past(i_wdata[5:0]))
    else $error("bit2 select not written");

  field3_write_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    reg_write_s |=> sel_r.bit3_src == $past(i_wdata[11:6]))
    else $error("bit3 select not written");

  reserved_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    reg_read_s |=> o_rdata[15:12] == 4'h0 && o_rdata[11:0] == $past({sel_r}))
    else $error("read data wrong");

  force_zero_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_hdr_valid && sel_r.bit2_src == 6'h30 |=> o_offset[2] == 1'b0)
    else $error("forced bit2 not zero");

  cell_pick_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_hdr_valid && sel_r.bit2_src < 6'h20
      |=> o_offset[2] == $past(i_hdr.cell_hdr[sel_r.bit2_src[4:0]]))
    else $error("cell header bit wrong");

  tandem_pick_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_hdr_valid && sel_r.bit3_src[5:4] == 2'b10
      |=> o_offset[3] == $past(i_hdr.tandem_hdr[sel_r.bit3_src[3:0]]))
    else $error("tandem header bit wrong");

  bus_pick_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_hdr_valid && sel_r.bit3_src > 6'h30
      |=> o_offset[3] == $past(i_hdr.bus_hdr[sel_r.bit3_src[3:0]]))
    else $error("bus header bit wrong");

  offset_pass_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_hdr_valid |=> o_offset_vld && o_offset[1:0] == $past(i_offset_lo)
      && o_offset[12:4] == $past(i_offset_hi))
    else $error("offset passthrough wrong");

  // ==========================================================================
  // Checks on each source for the other field, the idle paths and the read fields
  // ==========================================================================
  force_zero3_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_take_s ##0 src_is_force(sel_r.bit3_src)
      |=> o_offset[3] == 1'b0)
    else $error("forced bit3 not zero");

  bus_bit0_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_take_s ##0 (src_is_force(sel_r.bit2_src) && i_hdr.bus_hdr[0])
      |=> o_offset[2] == 1'b0)
    else $error("bus bit0 leaked through force code");

  cell_pick3_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_take_s ##0 src_is_cell(sel_r.bit3_src)
      |=> o_offset[3] == $past(i_hdr.cell_hdr[sel_r.bit3_src[4:0]]))
    else $error("cell header bit3 wrong");

  tandem_pick2_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_take_s ##0 src_is_tandem(sel_r.bit2_src)
      |=> o_offset[2] == $past(i_hdr.tandem_hdr[sel_r.bit2_src[3:0]]))
    else $error("tandem header bit2 wrong");

  bus_pick2_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_take_s ##0 src_is_bus(sel_r.bit2_src)
      |=> o_offset[2] == $past(i_hdr.bus_hdr[sel_r.bit2_src[3:0]]))
    else $error("bus header bit2 wrong");

  offset_top_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_take_s
      |=> o_offset[12] == $past(i_offset_hi[8]))
    else $error("offset top bit wrong");

  vld_rise_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_take_s
      |=> o_offset_vld)
    else $error("offset valid missing");

  vld_drop_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_idle_s
      |=> !o_offset_vld)
    else $error("offset valid without header");

  // Downstream may read the offset late, so it must not drift
  offset_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    hdr_idle_s
      |=> $stable(o_offset))
    else $error("offset changed without header");

  sel_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    reg_keep_s
      |=> $stable(sel_r))
    else $error("select changed without write");

  rdata_idle_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    reg_idle_s
      |=> o_rdata == '0)
    else $error("read data without read");

  rdata_bit2_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    reg_read_s
      |=> o_rdata[5:0] == $past(sel_r.bit2_src))
    else $error("bit2 select read wrong");

  rdata_bit3_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    reg_read_s
      |=> o_rdata[11:6] == $past(sel_r.bit3_src))
    else $error("bit3 select read wrong");

endmodule

// [verif/dps_bit_select_tb_top.sv]
// Self-checking bench for the discard pointer bit select block
`timescale 1ns/100ps
`include "dps_map.svh"
module dps_bit_select_tb_top import dps_pkg::*;;
  logic        i_clk, i_reset_n, i_wr, i_rd, i_hdr_valid, o_offset_vld;
  logic [9:0]  i_addr;
  logic [15:0] i_wdata, o_rdata;
  logic [1:0]  i_offset_lo;
  logic [8:0]  i_offset_hi;
  logic [12:0] o_offset;
  dps_hdr_t    i_hdr;
  int          error_cnt, compares, cyc;
  dps_bit_select dps_bit_select_i (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_hdr_valid, .i_hdr, .i_offset_lo, .i_offset_hi, .o_rdata, .o_offset, .o_offset_vld);
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ==========================================
  // Checks and bus tasks
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_wr(logic [9:0] a, logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic reg_rd(logic [9:0] a, logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
    @(posedge i_clk);
    #1 chk("rdata_idle", 16'h0000, o_rdata);
  endtask
  // Own model of the source decode; force code wins over bus header bit 0
  function automatic logic pick(logic [5:0] c, dps_hdr_t h);
    if (c == 6'h30) return 1'b0;
    if (c < 6'h20) return h.cell_hdr[c[4:0]];
    if (c < 6'h30) return h.tandem_hdr[c[3:0]];
    return h.bus_hdr[c[3:0]];
  endfunction
  task automatic send(dps_hdr_t h, logic [5:0] c3, logic [5:0] c2);
    logic [12:0] e;
    e = {c3, c2[2:0], pick(c3, h), pick(c2, h), c2[1:0]};
    @(posedge i_clk);
    i_hdr <= h;
    i_hdr_valid <= 1'b1;
    i_offset_lo <= c2[1:0];
    i_offset_hi <= {c3, c2[2:0]};
    @(posedge i_clk);
    i_hdr_valid <= 1'b0;
    i_hdr <= ~h;
    #1 chk("offset", {3'h0, e}, {3'h0, o_offset});
    chk("offset_vld", 16'h0001, {15'h0, o_offset_vld});
    @(posedge i_clk);
    #1 chk("offset_hold", {3'h0, e}, {3'h0, o_offset});
    chk("vld_drop", 16'h0000, {15'h0, o_offset_vld});
  endtask
  task automatic tally_and_finish();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well above the roughly 730 cycles the sequence needs
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {i_reset_n, i_wr, i_rd, i_hdr_valid, i_addr, i_wdata, i_offset_lo, i_offset_hi} = '0;
    i_hdr = '0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    reg_rd(`DPS_REG_OFFSET, 16'h0c30);
    reg_rd(10'h212, 16'h0000);
    reg_wr(10'h212, 16'h0555);
    reg_rd(`DPS_REG_OFFSET, 16'h0c30);
    // Every code on both fields, each header bit except bus bit 0 (never selectable) seen at both levels
    for (int k = 0; k < 64; k++)
    begin
      reg_wr(`DPS_REG_OFFSET, {4'hf, 6'(63 - k), 6'(k)});
      reg_rd(`DPS_REG_OFFSET, {4'h0, 6'(63 - k), 6'(k)});
      send(64'ha5c3_0f96_3c5a_e71b, 6'(63 - k), 6'(k));
      send(64'h5a3c_f069_c3a5_18e4, 6'(63 - k), 6'(k));
    end
    // Mid-run reset must bring back the forced selects and a clear offset
    reg_wr(`DPS_REG_OFFSET, 16'h0421);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1 chk("offset_rst", 16'h0000, {3'h0, o_offset});
    chk("vld_rst", 16'h0000, {15'h0, o_offset_vld});
    reg_rd(`DPS_REG_OFFSET, 16'h0c30);
    tally_and_finish();
  end
endmodule
